// *** usb_irq_pkg.sv ***
// Constants shared by the USB device interrupt source logic.
package usb_irq_pkg;
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned HZ_PER_MHZ = 1_000_000;
	localparam int unsigned SUSPEND_TIME_US = 3000;
	localparam int unsigned SUSPEND_CYCLES = (CLK_HZ / HZ_PER_MHZ) * SUSPEND_TIME_US;
	localparam int unsigned SUSPEND_CNT_W = $clog2(SUSPEND_CYCLES + 1);
	localparam int unsigned EP2_CAUSES = 3;
	localparam int unsigned EP3_CAUSES = 3;
	localparam int unsigned CTL_CAUSES = 5;
	localparam int unsigned TX_CAUSES = 1;
	localparam int unsigned SOURCES = 6;
	localparam int unsigned CAUSE_BUF0 = 0;
	localparam int unsigned CAUSE_BUF1 = 1;
	localparam int unsigned CAUSE_ERR = 2;
	localparam int unsigned C10_BUF = 0;
	localparam int unsigned C10_DONE = 1;
	localparam int unsigned C10_STATUS = 2;
	localparam int unsigned C10_SETUP = 3;
	localparam int unsigned C10_ERR = 4;
	localparam int unsigned SRC_EP2 = 0;
	localparam int unsigned SRC_EP3 = 1;
	localparam int unsigned SRC_CTL = 2;
	localparam int unsigned SRC_TX = 3;
	localparam int unsigned SRC_SUSP = 4;
	localparam int unsigned SRC_WAKE = 5;
	localparam logic [EP2_CAUSES-1:0] EP2_RESET = 3'h0;
	localparam logic [EP3_CAUSES-1:0] EP3_RESET = 3'h0;
	localparam logic [CTL_CAUSES-1:0] CTL_RESET = 5'h00;
	localparam logic [TX_CAUSES-1:0] TX_RESET = 1'h0;
	localparam logic FLAG_RESET = 1'h0;
	localparam logic [1:0] SYNC_RESET = 2'h0;
	typedef enum logic [1:0] {
		LINK_ACTIVE = 2'h1,
		LINK_SUSPENDED = 2'h2
	} link_state_t;
endpackage

// *** usb_device_irq_sources.sv ***
// USB device interrupt sources for endpoints two, three, ten, eleven, suspend and resume.
// Function
// - A finished endpoint two transfer latches buffer 0 ready, buffer 1 ready or transfer error.
// - A finished endpoint three transfer latches the same three causes as endpoint two.
// - The second control endpoint latches buffer, done, status, setup and error causes.
// - Endpoint eleven has only one cause, its buffer 0 becoming ready for writing.
// - With the module enabled, 3 ms of unbroken J state on the upstream pair raises suspend.
// - With both enables set, a J to SE0 or K change on the upstream pair raises resume.
`timescale 1ns/1ps
`default_nettype none
module usb_device_irq_sources #(
	parameter int unsigned SUSPEND_COUNT = usb_irq_pkg::SUSPEND_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic usb_module_enable_i,
	input wire logic resume_irq_enable_i,
	input wire logic upstream_plus_line_i,
	input wire logic upstream_minus_line_i,
	input wire logic [usb_irq_pkg::EP2_CAUSES-1:0] ep2_event_i,
	input wire logic [usb_irq_pkg::EP3_CAUSES-1:0] ep3_event_i,
	input wire logic [usb_irq_pkg::CTL_CAUSES-1:0] ctl_event_i,
	input wire logic [usb_irq_pkg::TX_CAUSES-1:0] tx_event_i,
	input wire logic [usb_irq_pkg::EP2_CAUSES-1:0] ep2_clear_i,
	input wire logic [usb_irq_pkg::EP3_CAUSES-1:0] ep3_clear_i,
	input wire logic [usb_irq_pkg::CTL_CAUSES-1:0] ctl_clear_i,
	input wire logic [usb_irq_pkg::TX_CAUSES-1:0] tx_clear_i,
	input wire logic suspend_clear_i,
	input wire logic resume_clear_i,
	input wire logic [usb_irq_pkg::SOURCES-1:0] source_enable_i,
	output logic [usb_irq_pkg::EP2_CAUSES-1:0] endpoint_two_source_o,
	output logic [usb_irq_pkg::EP3_CAUSES-1:0] endpoint_three_source_o,
	output logic [usb_irq_pkg::CTL_CAUSES-1:0] second_control_endpoint_source_o,
	output logic [usb_irq_pkg::TX_CAUSES-1:0] endpoint_eleven_source_o,
	output logic suspend_source_o,
	output logic resume_source_o,
	output logic device_irq_o
);
	import usb_irq_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Line synchronisers and line state decode.

	logic [1:0] dp_sync_reg;
	logic [1:0] dp_sync_next;
	logic [1:0] dm_sync_reg;
	logic [1:0] dm_sync_next;
	logic prev_j_reg;
	logic prev_j_next;
	logic line_j;

	always_comb begin
		dp_sync_next = {dp_sync_reg[0], upstream_plus_line_i};
		dm_sync_next = {dm_sync_reg[0], upstream_minus_line_i};
		line_j = dp_sync_reg[1] & ~dm_sync_reg[1];
		prev_j_next = line_j;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dp_sync_reg <= SYNC_RESET;
			dm_sync_reg <= SYNC_RESET;
			prev_j_reg <= FLAG_RESET;
		end else begin
			dp_sync_reg <= dp_sync_next;
			dm_sync_reg <= dm_sync_next;
			prev_j_reg <= prev_j_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Suspend timer and resume detector.

	link_state_t link_reg;
	link_state_t link_next;
	logic [SUSPEND_CNT_W-1:0] idle_cnt_reg;
	logic [SUSPEND_CNT_W-1:0] idle_cnt_next;
	logic suspend_hit;
	logic resume_hit;

	always_comb begin
		link_next = link_reg;
		idle_cnt_next = idle_cnt_reg;
		suspend_hit = 1'b0;
		if (!usb_module_enable_i || !line_j) begin
			idle_cnt_next = '0;
			link_next = LINK_ACTIVE;
		end else begin
			unique case (link_reg)
				LINK_ACTIVE: begin
					if (idle_cnt_reg == SUSPEND_CNT_W'(SUSPEND_COUNT - 1)) begin
						suspend_hit = 1'b1;
						link_next = LINK_SUSPENDED;
					end else begin
						idle_cnt_next = idle_cnt_reg + 1'b1;
					end
				end
				LINK_SUSPENDED: begin
					idle_cnt_next = idle_cnt_reg;
				end
				default: begin
					link_next = LINK_ACTIVE;
				end
			endcase
		end
		resume_hit = usb_module_enable_i & resume_irq_enable_i & prev_j_reg
			& ~dp_sync_reg[1];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			link_reg <= LINK_ACTIVE;
			idle_cnt_reg <= '0;
		end else begin
			link_reg <= link_next;
			idle_cnt_reg <= idle_cnt_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Latched cause bits and the interrupt request.

	logic [EP2_CAUSES-1:0] ep2_reg;
	logic [EP2_CAUSES-1:0] ep2_next;
	logic [EP3_CAUSES-1:0] ep3_reg;
	logic [EP3_CAUSES-1:0] ep3_next;
	logic [CTL_CAUSES-1:0] ctl_reg;
	logic [CTL_CAUSES-1:0] ctl_next;
	logic [TX_CAUSES-1:0] tx_reg;
	logic [TX_CAUSES-1:0] tx_next;
	logic susp_reg;
	logic susp_next;
	logic wake_reg;
	logic wake_next;
	logic irq_reg;
	logic irq_next;
	logic [SOURCES-1:0] pending;

	function automatic logic latch_bit(input logic held, input logic clr, input logic set);
		latch_bit = (held & ~clr) | set;
	endfunction

	always_comb begin
		for (int i = 0; i < EP2_CAUSES; i++) begin
			ep2_next[i] = latch_bit(ep2_reg[i], ep2_clear_i[i], ep2_event_i[i]);
		end
		for (int i = 0; i < EP3_CAUSES; i++) begin
			ep3_next[i] = latch_bit(ep3_reg[i], ep3_clear_i[i], ep3_event_i[i]);
		end
		for (int i = 0; i < CTL_CAUSES; i++) begin
			ctl_next[i] = latch_bit(ctl_reg[i], ctl_clear_i[i], ctl_event_i[i]);
		end
		tx_next = latch_bit(tx_reg[0], tx_clear_i[0], tx_event_i[0]);
		susp_next = latch_bit(susp_reg, suspend_clear_i, suspend_hit);
		wake_next = latch_bit(wake_reg, resume_clear_i, resume_hit);
		pending = '0;
		pending[SRC_EP2] = |ep2_reg;
		pending[SRC_EP3] = |ep3_reg;
		pending[SRC_CTL] = |ctl_reg;
		pending[SRC_TX] = |tx_reg;
		pending[SRC_SUSP] = susp_reg;
		pending[SRC_WAKE] = wake_reg;
		irq_next = |(pending & source_enable_i);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ep2_reg <= EP2_RESET;
			ep3_reg <= EP3_RESET;
			ctl_reg <= CTL_RESET;
			tx_reg <= TX_RESET;
			susp_reg <= FLAG_RESET;
			wake_reg <= FLAG_RESET;
			irq_reg <= FLAG_RESET;
		end else begin
			ep2_reg <= ep2_next;
			ep3_reg <= ep3_next;
			ctl_reg <= ctl_next;
			tx_reg <= tx_next;
			susp_reg <= susp_next;
			wake_reg <= wake_next;
			irq_reg <= irq_next;
		end
	end

	assign endpoint_two_source_o = ep2_reg;
	assign endpoint_three_source_o = ep3_reg;
	assign second_control_endpoint_source_o = ctl_reg;
	assign endpoint_eleven_source_o = tx_reg;
	assign suspend_source_o = susp_reg;
	assign resume_source_o = wake_reg;
	assign device_irq_o = irq_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	property p_ep2_set;
		@(posedge clk_i) disable iff (rst_i)
		(|ep2_event_i) |=> ((ep2_reg & $past(ep2_event_i)) == $past(ep2_event_i));
	endproperty
	a_ep2_set: assert property (p_ep2_set)
		else $error("Endpoint two cause not latched.");

	property p_ep3_set;
		@(posedge clk_i) disable iff (rst_i)
		(|ep3_event_i) |=> ((ep3_reg & $past(ep3_event_i)) == $past(ep3_event_i));
	endproperty
	a_ep3_set: assert property (p_ep3_set)
		else $error("Endpoint three cause not latched.");

	property p_ctl_set;
		@(posedge clk_i) disable iff (rst_i)
		ctl_event_i[C10_SETUP] |=> ctl_reg[C10_SETUP] && (ctl_reg[C10_ERR] ||
			!$past(ctl_event_i[C10_ERR]));
	endproperty
	a_ctl_set: assert property (p_ctl_set)
		else $error("Control endpoint cause lost.");

	property p_tx_hold;
		@(posedge clk_i) disable iff (rst_i)
		$rose(tx_reg[0]) |-> $past(tx_event_i[0]);
	endproperty
	a_tx_hold: assert property (p_tx_hold)
		else $error("Endpoint eleven set without cause.");

	property p_suspend_time;
		@(posedge clk_i) disable iff (rst_i)
		suspend_hit |-> usb_module_enable_i && idle_cnt_reg == SUSPEND_CNT_W'(SUSPEND_COUNT - 1)
			##1 susp_reg;
	endproperty
	a_suspend_time: assert property (p_suspend_time)
		else $error("Suspend raised off time.");

	property p_resume_gate;
		@(posedge clk_i) disable iff (rst_i)
		$rose(wake_reg) |-> $past(usb_module_enable_i) && $past(resume_irq_enable_i)
			&& $past(prev_j_reg) && !$past(dp_sync_reg[1]);
	endproperty
	a_resume_gate: assert property (p_resume_gate)
		else $error("Resume raised while gated.");

	property p_latch_hold;
		@(posedge clk_i) disable iff (rst_i)
		(susp_reg && !suspend_clear_i) |=> susp_reg;
	endproperty
	a_latch_hold: assert property (p_latch_hold)
		else $error("Suspend cause dropped uncleared.");

	property p_wake_clear;
		@(posedge clk_i) disable iff (rst_i)
		(resume_clear_i && !resume_hit) |=> !wake_reg;
	endproperty
	a_wake_clear: assert property (p_wake_clear)
		else $error("Resume cause kept after clear.");

	property p_irq_follow;
		@(posedge clk_i) disable iff (rst_i)
		(source_enable_i[SRC_WAKE] && wake_reg) |=> device_irq_o;
	endproperty
	a_irq_follow: assert property (p_irq_follow)
		else $error("Request missing for resume.");
endmodule
`default_nettype wire

// *** usb_host_model.sv ***
// Host model that drives the upstream differential pair.
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
	input wire logic [1:0] line_state_i,
	output logic upstream_plus_line_o,
	output logic upstream_minus_line_o
);
	// State 0 is J, 1 is K, 2 is SE0; the host always drives the pair.
	always_comb begin
		upstream_plus_line_o = (line_state_i == 2'h0);
		upstream_minus_line_o = (line_state_i == 2'h1);
	end
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking testbench for the USB device interrupt sources.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import usb_irq_pkg::*;
	localparam int SUS_N = 20;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic mod_en = 1'b0;
	logic wake_en = 1'b0;
	logic [1:0] line = 2'h2;
	logic [11:0] ev = 12'h000;
	logic [11:0] cl = 12'h000;
	logic susp_clr = 1'b0;
	logic wake_clr = 1'b0;
	logic [5:0] src_en = 6'h00;
	wire logic dp, dm, susp, wake, irq;
	wire logic [2:0] s2, s3;
	wire logic [4:0] s10;
	wire logic [0:0] s11;
	wire logic [11:0] all_src = {s11, s10, s3, s2};
	int miscompares = 0;
	int num_checks = 0;
	always #10 clk_i = ~clk_i;
	////////////////////////////////////////////////////////////////////////////////
	usb_host_model host (.line_state_i(line), .upstream_plus_line_o(dp),
		.upstream_minus_line_o(dm));
	usb_device_irq_sources #(.SUSPEND_COUNT(SUS_N)) dut (.clk_i(clk_i), .rst_i(rst_i),
		.usb_module_enable_i(mod_en), .resume_irq_enable_i(wake_en),
		.upstream_plus_line_i(dp), .upstream_minus_line_i(dm),
		.ep2_event_i(ev[2:0]), .ep3_event_i(ev[5:3]), .ctl_event_i(ev[10:6]),
		.tx_event_i(ev[11:11]), .ep2_clear_i(cl[2:0]), .ep3_clear_i(cl[5:3]),
		.ctl_clear_i(cl[10:6]), .tx_clear_i(cl[11:11]), .suspend_clear_i(susp_clr),
		.resume_clear_i(wake_clr), .source_enable_i(src_en), .endpoint_two_source_o(s2),
		.endpoint_three_source_o(s3), .second_control_endpoint_source_o(s10),
		.endpoint_eleven_source_o(s11), .suspend_source_o(susp), .resume_source_o(wake),
		.device_irq_o(irq));
	////////////////////////////////////////////////////////////////////////////////
	task automatic tick();
		@(posedge clk_i);
	endtask
	task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic summarize();
		if (miscompares == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic wait_src(input bit want_rsm, input int limit, output int n);
		n = 0;
		do begin
			tick();
			#1 n++;
		end while ((want_rsm ? wake : susp) !== 1'b1 && n < limit);
		if ((want_rsm ? wake : susp) !== 1'b1) begin
			miscompares++;
			summarize();
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic ep_causes();
		logic [11:0] m;
		int s;
		for (int i = 0; i < 12; i++) begin
			m = 12'h001 << i;
			s = (i < 3) ? 0 : (i < 6) ? 1 : (i < 11) ? 2 : 3;
			tick();
			ev <= m;
			src_en <= i[0] ? (6'h3f & ~(6'h01 << s)) : 6'h3f;
			tick();
			ev <= 12'h000;
			#1 check("cause latch", all_src, m);
			tick();
			#1 check("cause irq", {11'h000, irq}, {11'h000, ~i[0]});
			tick();
			ev <= m;
			cl <= m;
			tick();
			ev <= 12'h000;
			cl <= 12'h000;
			#1 check("set wins", all_src, m);
			tick();
			cl <= m;
			tick();
			cl <= 12'h000;
			#1 check("cause clear", all_src, 12'h000);
			tick();
			#1 check("irq drop", {11'h000, irq}, 12'h000);
		end
	endtask
	task automatic suspend_resume();
		int n;
		tick();
		mod_en <= 1'b1;
		wake_en <= 1'b1;
		line <= 2'h0;
		wait_src(1'b0, 60, n);
		check("suspend delay", {11'h000, n >= SUS_N && n <= SUS_N + 5}, 12'h001);
		tick();
		#1 check("suspend irq", {11'h000, irq}, 12'h001);
		tick();
		susp_clr <= 1'b1;
		tick();
		susp_clr <= 1'b0;
		repeat (30) tick();
		#1 check("suspend once", {11'h000, susp}, 12'h000);
		tick();
		line <= 2'h1;
		wait_src(1'b1, 8, n);
		check("resume on k", {11'h000, wake}, 12'h001);
		tick();
		wake_clr <= 1'b1;
		wake_en <= 1'b0;
		line <= 2'h0;
		tick();
		wake_clr <= 1'b0;
		repeat (4) tick();
		line <= 2'h2;
		repeat (10) tick();
		#1 check("resume masked", {11'h000, wake}, 12'h000);
		tick();
		wake_en <= 1'b1;
		line <= 2'h0;
		repeat (4) tick();
		line <= 2'h2;
		wait_src(1'b1, 8, n);
		check("resume on se0", {11'h000, wake}, 12'h001);
		tick();
		mod_en <= 1'b0;
		susp_clr <= 1'b1;
		wake_clr <= 1'b1;
		line <= 2'h0;
		tick();
		susp_clr <= 1'b0;
		wake_clr <= 1'b0;
		repeat (40) tick();
		#1 check("suspend off", {11'h000, susp}, 12'h000);
		tick();
		line <= 2'h2;
		repeat (10) tick();
		#1 check("resume module off", {11'h000, wake}, 12'h000);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) tick();
		rst_i <= 1'b0;
		#1 check("reset state", all_src | {11'h000, susp | wake | irq}, 12'h000);
		ep_causes();
		suspend_resume();
		summarize();
	end
endmodule
`default_nettype wire
